/* File: core/cdec_defines.svh */
// Constants for the compact instruction decoder
`ifndef CDEC_DEFINES_SVH
`define CDEC_DEFINES_SVH
`define CDEC_NATIVE_AL 4'hE
`define CDEC_REG_SP 4'hD
`define CDEC_REG_PC 4'hF
`define CDEC_REG_LR 4'hE
`define CDEC_OP_AND 4'h0
`define CDEC_OP_EOR 4'h1
`define CDEC_OP_SUB 4'h2
`define CDEC_OP_RSB 4'h3
`define CDEC_OP_ADD 4'h4
`define CDEC_OP_ADC 4'h5
`define CDEC_OP_SBC 4'h6
`define CDEC_OP_TST 4'h8
`define CDEC_OP_CMP 4'hA
`define CDEC_OP_CMN 4'hB
`define CDEC_OP_ORR 4'hC
`define CDEC_OP_MOV 4'hD
`define CDEC_OP_BIC 4'hE
`define CDEC_OP_MVN 4'hF
`define CDEC_SH_LSL 2'h0
`define CDEC_SH_LSR 2'h1
`define CDEC_SH_ASR 2'h2
`define CDEC_SH_ROR 2'h3
`endif

/* File: core/cdec_expand.sv */
// Combinational expansion of one compressed halfword into a native word
`include "cdec_defines.svh"
module cdec_expand (
   // Compressed word
   input wire logic [15:0] half,
   // Expanded result
   output logic [31:0] native,
   output cdec_pkg::cdec_format_t format,
   output logic sets_flags,
   output logic undefined,
   output logic long_second
);
   function automatic logic [31:0] dp(input logic [3:0] op, input logic s,
      input logic [3:0] rn, input logic [3:0] rd, input logic imm, input logic [11:0] op2);
      dp = {`CDEC_NATIVE_AL, 2'h0, imm, op, s, rn, rd, op2};
   endfunction
   logic [3:0] rd3;
   logic [3:0] rs3;
   logic [3:0] rb3;
   logic [3:0] ro3;
   logic [3:0] hd;
   logic [3:0] hs;
   always_comb begin
      rd3 = {1'b0, half[2:0]};
      rs3 = {1'b0, half[5:3]};
      rb3 = {1'b0, half[5:3]};
      ro3 = {1'b0, half[8:6]};
      hd = {half[7], half[2:0]};
      hs = {half[6], half[5:3]};
      native = 32'h0000_0000;
      format = cdec_pkg::CDEC_F_UNDEF;
      sets_flags = 1'b0;
      undefined = 1'b0;
      long_second = 1'b0;
      if (half[15:13] == 3'h0 && half[12:11] != 2'h3) begin
         format = cdec_pkg::CDEC_F_SHIFT;
         sets_flags = 1'b1;
         native = dp(`CDEC_OP_MOV, 1'b1, 4'h0, rd3, 1'b0,
            {half[10:6], half[12:11], 1'b0, rs3});
      end else if (half[15:11] == 5'h03) begin
         format = cdec_pkg::CDEC_F_ADDSUB;
         sets_flags = 1'b1;
         native = dp(half[9] ? `CDEC_OP_SUB : `CDEC_OP_ADD, 1'b1, rs3, rd3, half[10],
            half[10] ? {9'h000, half[8:6]} : {8'h00, {1'b0, half[8:6]}});
      end else if (half[15:13] == 3'h1) begin
         format = cdec_pkg::CDEC_F_IMM8;
         sets_flags = 1'b1;
         case (half[12:11])
            2'h0: native = dp(`CDEC_OP_MOV, 1'b1, 4'h0, {1'b0, half[10:8]}, 1'b1,
               {4'h0, half[7:0]});
            2'h1: native = dp(`CDEC_OP_CMP, 1'b1, {1'b0, half[10:8]}, 4'h0, 1'b1,
               {4'h0, half[7:0]});
            2'h2: native = dp(`CDEC_OP_ADD, 1'b1, {1'b0, half[10:8]}, {1'b0, half[10:8]},
               1'b1, {4'h0, half[7:0]});
            default: native = dp(`CDEC_OP_SUB, 1'b1, {1'b0, half[10:8]},
               {1'b0, half[10:8]}, 1'b1, {4'h0, half[7:0]});
         endcase
      end else if (half[15:10] == 6'h10) begin
         format = cdec_pkg::CDEC_F_ALU;
         sets_flags = 1'b1;
         case (half[9:6])
            4'h0: native = dp(`CDEC_OP_AND, 1'b1, rd3, rd3, 1'b0, {8'h00, rs3});
            4'h1: native = dp(`CDEC_OP_EOR, 1'b1, rd3, rd3, 1'b0, {8'h00, rs3});
            4'h2: native = dp(`CDEC_OP_MOV, 1'b1, 4'h0, rd3, 1'b0,
               {rs3, 1'b0, `CDEC_SH_LSL, 1'b1, rd3});
            4'h3: native = dp(`CDEC_OP_MOV, 1'b1, 4'h0, rd3, 1'b0,
               {rs3, 1'b0, `CDEC_SH_LSR, 1'b1, rd3});
            4'h4: native = dp(`CDEC_OP_MOV, 1'b1, 4'h0, rd3, 1'b0,
               {rs3, 1'b0, `CDEC_SH_ASR, 1'b1, rd3});
            4'h5: native = dp(`CDEC_OP_ADC, 1'b1, rd3, rd3, 1'b0, {8'h00, rs3});
            4'h6: native = dp(`CDEC_OP_SBC, 1'b1, rd3, rd3, 1'b0, {8'h00, rs3});
            4'h7: native = dp(`CDEC_OP_MOV, 1'b1, 4'h0, rd3, 1'b0,
               {rs3, 1'b0, `CDEC_SH_ROR, 1'b1, rd3});
            4'h8: native = dp(`CDEC_OP_TST, 1'b1, rd3, 4'h0, 1'b0, {8'h00, rs3});
            4'h9: native = dp(`CDEC_OP_RSB, 1'b1, rs3, rd3, 1'b1, 12'h000);
            4'hA: native = dp(`CDEC_OP_CMP, 1'b1, rd3, 4'h0, 1'b0, {8'h00, rs3});
            4'hB: native = dp(`CDEC_OP_CMN, 1'b1, rd3, 4'h0, 1'b0, {8'h00, rs3});
            4'hC: native = dp(`CDEC_OP_ORR, 1'b1, rd3, rd3, 1'b0, {8'h00, rs3});
            4'hD: native = {`CDEC_NATIVE_AL, 7'h00, 1'b1, rd3, 4'h0, rd3, 4'h9, rs3};
            4'hE: native = dp(`CDEC_OP_BIC, 1'b1, rd3, rd3, 1'b0, {8'h00, rs3});
            default: native = dp(`CDEC_OP_MVN, 1'b1, 4'h0, rd3, 1'b0, {8'h00, rs3});
         endcase
      end else if (half[15:10] == 6'h11) begin
         format = cdec_pkg::CDEC_F_HIREG;
         case (half[9:8])
            2'h0: native = dp(`CDEC_OP_ADD, 1'b0, hd, hd, 1'b0, {8'h00, hs});
            2'h1: begin
               sets_flags = 1'b1;
               native = dp(`CDEC_OP_CMP, 1'b1, hd, 4'h0, 1'b0, {8'h00, hs});
            end
            2'h2: native = dp(`CDEC_OP_MOV, 1'b0, 4'h0, hd, 1'b0, {8'h00, hs});
            default: begin
               undefined = half[7];
               native = {`CDEC_NATIVE_AL, 24'h12FFF1, hs};
            end
         endcase
      end else if (half[15:11] == 5'h09) begin
         format = cdec_pkg::CDEC_F_PCLOAD;
         native = {`CDEC_NATIVE_AL, 8'h59, `CDEC_REG_PC, {1'b0, half[10:8]},
            2'h0, half[7:0], 2'h0};
      end else if (half[15:12] == 4'h5 && !half[9]) begin
         format = cdec_pkg::CDEC_F_LSREG;
         native = {`CDEC_NATIVE_AL, 5'h0F, half[10], 1'b0, half[11], rb3, rd3,
            8'h00, ro3};
      end else if (half[15:12] == 4'h5) begin
         format = cdec_pkg::CDEC_F_LSSIGN;
         native = {`CDEC_NATIVE_AL, 7'h0C, !(half[11] == 1'b0 && half[10] == 1'b0),
            rb3, rd3, 4'h0, 1'b1, half[10], half[11] | !half[10], 1'b1, ro3};
      end else if (half[15:13] == 3'h3) begin
         format = cdec_pkg::CDEC_F_LSIMM;
         native = {`CDEC_NATIVE_AL, 5'h0B, half[12], 1'b0, half[11], rb3, rd3,
            half[12] ? {7'h00, half[10:6]} : {5'h00, half[10:6], 2'h0}};
      end else if (half[15:12] == 4'h8) begin
         format = cdec_pkg::CDEC_F_LSHALF;
         native = {`CDEC_NATIVE_AL, 7'h0D, half[11], rb3, rd3, 2'h0, half[10:9],
            4'hB, half[8:6], 1'b0};
      end else if (half[15:12] == 4'h9) begin
         format = cdec_pkg::CDEC_F_SPLS;
         native = {`CDEC_NATIVE_AL, 7'h2C, half[11], `CDEC_REG_SP, {1'b0, half[10:8]},
            2'h0, half[7:0], 2'h0};
      end else if (half[15:12] == 4'hA) begin
         format = cdec_pkg::CDEC_F_LDADDR;
         native = dp(`CDEC_OP_ADD, 1'b0, half[11] ? `CDEC_REG_SP : `CDEC_REG_PC,
            {1'b0, half[10:8]}, 1'b1, {4'hF, half[7:0]});
      end else if (half[15:8] == 8'hB0) begin
         format = cdec_pkg::CDEC_F_SPADJ;
         native = dp(half[7] ? `CDEC_OP_SUB : `CDEC_OP_ADD, 1'b0, `CDEC_REG_SP,
            `CDEC_REG_SP, 1'b1, {4'hF, 1'b0, half[6:0]});
      end else if (half[15:12] == 4'hB && half[10:9] == 2'h2) begin
         format = cdec_pkg::CDEC_F_PUSHPOP;
         native = half[11]
            ? {`CDEC_NATIVE_AL, 12'h8BD, half[8], 7'h00, half[7:0]}
            : {`CDEC_NATIVE_AL, 12'h92D, 1'b0, half[8], 6'h00, half[7:0]};
      end else if (half[15:12] == 4'hC) begin
         format = cdec_pkg::CDEC_F_MULTI;
         native = {`CDEC_NATIVE_AL, 7'h45, half[11], {1'b0, half[10:8]}, 8'h00, half[7:0]};
      end else if (half[15:8] == 8'hDF) begin
         format = cdec_pkg::CDEC_F_SWINT;
         native = {`CDEC_NATIVE_AL, 4'hF, 16'h0000, half[7:0]};
      end else if (half[15:12] == 4'hD && half[11:8] != 4'hE) begin
         format = cdec_pkg::CDEC_F_BCOND;
         native = {half[11:8], 4'hA, {15{half[7]}}, half[7:0], 1'b0};
      end else if (half[15:11] == 5'h1C) begin
         format = cdec_pkg::CDEC_F_BRANCH;
         native = {`CDEC_NATIVE_AL, 4'hA, {12{half[10]}}, half[10:0], 1'b0};
      end else if (half[15:12] == 4'hF) begin
         format = cdec_pkg::CDEC_F_LONGBL;
         long_second = half[11];
         native = half[11]
            ? {`CDEC_NATIVE_AL, 8'h2A, `CDEC_REG_LR, `CDEC_REG_PC, {1'b0, half[10:0]}}
            : {`CDEC_NATIVE_AL, 8'h2A, `CDEC_REG_PC, `CDEC_REG_LR, {1'b0, half[10:0]}};
      end else begin
         undefined = 1'b1;
      end
   end
endmodule

/* File: core/cdec_pkg.sv */
// Types shared by the compact instruction decoder
package cdec_pkg;
   typedef enum logic [4:0] {
      CDEC_F_SHIFT = 5'h01, CDEC_F_ADDSUB = 5'h02, CDEC_F_IMM8 = 5'h03,
      CDEC_F_ALU = 5'h04, CDEC_F_HIREG = 5'h05, CDEC_F_PCLOAD = 5'h06,
      CDEC_F_LSREG = 5'h07, CDEC_F_LSSIGN = 5'h08, CDEC_F_LSIMM = 5'h09,
      CDEC_F_LSHALF = 5'h0A, CDEC_F_SPLS = 5'h0B, CDEC_F_LDADDR = 5'h0C,
      CDEC_F_SPADJ = 5'h0D, CDEC_F_PUSHPOP = 5'h0E, CDEC_F_MULTI = 5'h0F,
      CDEC_F_BCOND = 5'h10, CDEC_F_SWINT = 5'h11, CDEC_F_BRANCH = 5'h12,
      CDEC_F_LONGBL = 5'h13, CDEC_F_UNDEF = 5'h00
   } cdec_format_t;
   typedef struct packed {
      logic out_valid;
      logic [31:0] native;
      cdec_format_t format;
      logic sets_flags;
      logic undefined;
      logic long_second;
   } cdec_state_t;
endpackage

/* File: core/cdec_top.sv */
// Compact instruction decoder: registers each expanded halfword
// Functional notes
// - Accept exactly 16-bit compressed words
// - Expand each word to native 32-bit
// - 0101 with bit9 clear: register-offset load/store
// - 011 prefix: immediate-offset load/store
// - 10110000 prefix: stack pointer adjust
// - 1111 prefix: long branch-link half
// - Add in formats 5,12,13 keeps flags
// - Hi-register move keeps flags
`include "cdec_defines.svh"
module cdec_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // From fetch
   input wire logic in_valid,
   input wire logic [15:0] in_half,
   // To execute
   output logic out_valid,
   output logic [31:0] out_native,
   output cdec_pkg::cdec_format_t out_format,
   output logic out_sets_flags,
   output logic out_undefined,
   output logic out_long_second
);
   cdec_pkg::cdec_state_t st_ff;
   cdec_pkg::cdec_state_t nxt_st;
   logic [31:0] x_native;
   cdec_pkg::cdec_format_t x_format;
   logic x_flags;
   logic x_undef;
   logic x_second;

   // ---------------------------------------------
   // Expansion
   // ---------------------------------------------
   cdec_expand u_expand (
      .half(in_half),
      .native(x_native),
      .format(x_format),
      .sets_flags(x_flags),
      .undefined(x_undef),
      .long_second(x_second)
   );

   // ---------------------------------------------
   // Output stage
   // ---------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.out_valid = in_valid;
      if (in_valid) begin
         nxt_st.native = x_native;
         nxt_st.format = x_format;
         nxt_st.sets_flags = x_flags;
         nxt_st.undefined = x_undef;
         nxt_st.long_second = x_second;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '{out_valid: 1'b0, native: 32'h0000_0000,
            format: cdec_pkg::CDEC_F_UNDEF, sets_flags: 1'b0, undefined: 1'b0,
            long_second: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign out_valid = st_ff.out_valid;
   assign out_native = st_ff.native;
   assign out_format = st_ff.format;
   assign out_sets_flags = st_ff.sets_flags;
   assign out_undefined = st_ff.undefined;
   assign out_long_second = st_ff.long_second;
endmodule

/* File: verif/cdec_fetch_model.sv */
// Fetch stage model that presents halfwords to the decoder
module cdec_fetch_model (
   // To decoder
   output logic in_valid,
   output logic [15:0] in_half
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      in_valid = 1'h0;
      in_half = 16'h0000;
   end
   task automatic send(input logic [15:0] h);
      in_valid = 1'h1;
      in_half = h;
   endtask
   // Idle word lines do not keep the last halfword
   task automatic idle();
      in_valid = 1'h0;
      in_half = ~in_half;
   endtask
endmodule

/* File: verif/cdec_tb_top.sv */
// Self-checking testbench for the compact instruction decoder
module cdec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst;
   logic in_valid;
   logic [15:0] in_half;
   logic out_valid;
   logic [31:0] out_native;
   cdec_pkg::cdec_format_t out_format;
   logic out_sets_flags;
   logic out_undefined;
   logic out_long_second;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   // Halfword, format code, flags update, second half
   logic [22:0] tab [28] = '{
      {16'h0000, 5'h01, 2'h2}, {16'h1840, 5'h02, 2'h2}, {16'h2000, 5'h03, 2'h2},
      {16'h4000, 5'h04, 2'h2}, {16'h4480, 5'h05, 2'h0}, {16'h4680, 5'h05, 2'h0},
      {16'h4540, 5'h05, 2'h2}, {16'h4800, 5'h06, 2'h0}, {16'h5800, 5'h07, 2'h0},
      {16'h5400, 5'h07, 2'h0}, {16'h5E00, 5'h08, 2'h0}, {16'h6800, 5'h09, 2'h0},
      {16'h7000, 5'h09, 2'h0}, {16'h8000, 5'h0A, 2'h0}, {16'h9000, 5'h0B, 2'h0},
      {16'hA800, 5'h0C, 2'h0}, {16'hB080, 5'h0D, 2'h0}, {16'hB07F, 5'h0D, 2'h0},
      {16'hB400, 5'h0E, 2'h0}, {16'hC000, 5'h0F, 2'h0}, {16'hD000, 5'h10, 2'h0},
      {16'hDF00, 5'h11, 2'h0}, {16'hE000, 5'h12, 2'h0}, {16'hF000, 5'h13, 2'h0},
      {16'hF800, 5'h13, 2'h1}, {16'hDE00, 5'h00, 2'h0}, {16'hB100, 5'h00, 2'h0},
      {16'hE800, 5'h00, 2'h0}};
   cdec_top u_cdec_top (.clk, .rst, .in_valid, .in_half, .out_valid, .out_native,
      .out_format, .out_sets_flags, .out_undefined, .out_long_second);
   cdec_fetch_model u_cdec_fetch_model (.in_valid, .in_half);
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_sim();
      end
   end
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic sc_walk();
      u_cdec_fetch_model.send(16'h1840);
      step();
      u_cdec_fetch_model.idle();
      chk("valid", 32'(out_valid), 32'h1);
      chk("native", out_native, 32'hE0900001);
      step();
      chk("valid idle", 32'(out_valid), 32'h0);
      chk("format hold", 32'(out_format), 32'h2);
   endtask
   // Field placement in the expanded word for a few forms
   task automatic sc_native();
      u_cdec_fetch_model.send(16'h5853);
      step();
      u_cdec_fetch_model.send(16'h6853);
      chk("native lsreg", out_native, 32'hE7923001);
      step();
      u_cdec_fetch_model.send(16'hB085);
      chk("native lsimm", out_native, 32'hE5923004);
      step();
      u_cdec_fetch_model.send(16'hF7FF);
      chk("native spadj", out_native, 32'hE24DDF05);
      step();
      u_cdec_fetch_model.send(16'hF801);
      chk("native first", out_native, 32'hE2AFE7FF);
      step();
      u_cdec_fetch_model.send(16'h5A53);
      chk("native second", out_native, 32'hE2AEF001);
      step();
      u_cdec_fetch_model.send(16'h4480);
      chk("native ldrh", out_native, 32'hE19230B1);
      step();
      u_cdec_fetch_model.idle();
      chk("native hi add", out_native, 32'hE0888000);
   endtask
   task automatic sc_formats();
      u_cdec_fetch_model.send(tab[0][22:7]);
      for (int i = 0; i < 28; i++) begin
         step();
         if (i < 27) u_cdec_fetch_model.send(tab[i + 1][22:7]);
         else u_cdec_fetch_model.idle();
         chk("valid", 32'(out_valid), 32'h1);
         chk("format", 32'(out_format), {27'h0, tab[i][6:2]});
         chk("undefined", 32'(out_undefined), {31'h0, tab[i][6:2] == 5'h00});
         chk("flags", 32'(out_sets_flags), 32'(tab[i][1]));
         if (tab[i][6:2] == 5'h13) chk("second", 32'(out_long_second), 32'(tab[i][0]));
      end
   endtask
   task automatic sc_reset();
      u_cdec_fetch_model.send(16'h0000);
      step();
      u_cdec_fetch_model.idle();
      rst = 1'h1;
      #2;
      chk("reset valid", 32'(out_valid), 32'h0);
      chk("reset format", 32'(out_format), 32'h0);
      step();
      rst = 1'h0;
      u_cdec_fetch_model.send(16'hF800);
      step();
      u_cdec_fetch_model.idle();
      chk("second", 32'(out_long_second), 32'h1);
      chk("second native", out_native, 32'hE2AEF000);
   endtask
   initial begin
      rst = 1'h1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'h0;
      sc_walk();
      sc_formats();
      sc_native();
      sc_reset();
      end_sim();
   end
endmodule

/* File: verif/cdec_top_sva.sv */
// Port-level assertions for the compact instruction decoder
module cdec_top_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // From fetch
   input wire logic in_valid,
   input wire logic [15:0] in_half,
   // To execute
   input wire logic out_valid,
   input wire logic [31:0] out_native,
   input wire cdec_pkg::cdec_format_t out_format,
   input wire logic out_sets_flags,
   input wire logic out_undefined,
   input wire logic out_long_second
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_valid_follow: assert property (in_valid |=> out_valid)
      else $error("no result after a taken halfword");
   a_valid_drop: assert property (!in_valid |=> !out_valid)
      else $error("result without a taken halfword");
   a_fields_hold: assert property (
      !in_valid |=> $stable(out_native) && $stable(out_format))
      else $error("result fields changed while idle");
   a_lsreg_form: assert property (
      in_valid && in_half[15:12] == 4'h5 && !in_half[9]
      |=> out_format == cdec_pkg::CDEC_F_LSREG && !out_sets_flags)
      else $error("register offset transfer misdecoded");
   a_lsimm_form: assert property (
      in_valid && in_half[15:13] == 3'h3
      |=> out_format == cdec_pkg::CDEC_F_LSIMM && !out_sets_flags)
      else $error("immediate offset transfer misdecoded");
   a_spadj_form: assert property (
      in_valid && in_half[15:8] == 8'hB0
      |=> out_format == cdec_pkg::CDEC_F_SPADJ && !out_sets_flags)
      else $error("stack adjust misdecoded");
   a_long_half: assert property (
      in_valid && in_half[15:12] == 4'hF
      |=> out_format == cdec_pkg::CDEC_F_LONGBL && out_long_second == $past(in_half[11]))
      else $error("long jump half misdecoded");
   a_hireg_flags: assert property (
      in_valid && in_half[15:10] == 6'h11 && in_half[9:8] != 2'h1 |=> !out_sets_flags)
      else $error("high register add or copy updates flags");
   a_undef_gap: assert property (
      in_valid && in_half[15:11] == 5'h1D
      |=> out_undefined && out_format == cdec_pkg::CDEC_F_UNDEF)
      else $error("unmatched halfword not flagged");
   a_alu_flags: assert property (
      in_valid && in_half[15:10] == 6'h10 |=> out_sets_flags)
      else $error("logic operation leaves flags");
endmodule
bind cdec_top cdec_top_sva u_cdec_top_sva (.clk, .rst, .in_valid, .in_half, .out_valid,
   .out_native, .out_format, .out_sets_flags, .out_undefined, .out_long_second);
